// ===== hw/pcs_map.svh
// constants for the pad configuration context save engine
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
`define PCS_START_SAVE_BIT 1
`define PCS_DIV_SEL_BIT 2
`define PCS_DIV_SEL_RESET 1'b0
`define PCS_DIV_SLOW 3'd4
`define PCS_DIV_FAST 3'd2
`define PCS_NUM_PAD_REGS 200
`endif

// ===== hw/pcs_pkg.sv
// types for the pad configuration context save engine
`default_nettype none
package pcs_pkg;
  typedef enum logic [3:0] {
    PCS_IDLE = 4'h1,
    PCS_SAVE = 4'h2,
    PCS_REST = 4'h4,
    PCS_DONE = 4'h8
  } pcs_state_type;
  typedef struct packed {
    logic start_save_bit;
    logic wake_clock_divider_select;
  } pcs_ctrl_type;
endpackage
`default_nettype wire

// ===== hw/pcs_context_save.sv
// pad configuration save-and-restore engine
//
// Overview of operation
// - a save copies every pad configuration register into scratch memory, none skipped.
// - on exit from off mode each pad register is restored from scratch memory.
// - divider select low runs the engine at the clock divided by 4, high divided by 2.
// - a zero-to-one change on the start-save control bit while idle or done starts a save.
// - done rises only after the last scratch write, even if a port access hits it.
`include "pcs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pcs_context_save
  import pcs_pkg::*;
#(
  parameter int NUM_REGS = `PCS_NUM_PAD_REGS,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // control
  input wire pcs_ctrl_type ctrl_i,
  input wire logic off_exit_i,
  output logic save_done_flag_o,
  output logic busy_o,
  // register port access
  input wire logic port_req_i,
  input wire logic [$clog2(NUM_REGS)-1:0] port_addr_i,
  input wire logic port_we_i,
  input wire logic [DW-1:0] port_wdata_i,
  output logic [DW-1:0] port_rdata_o,
  // scratch readback
  input wire logic [$clog2(NUM_REGS)-1:0] scr_addr_i,
  output logic [DW-1:0] scr_rdata_o
);
  localparam int AW = $clog2(NUM_REGS);
  localparam logic [AW-1:0] LAST = AW'(NUM_REGS - 1);

  logic [DW-1:0] pad_q [NUM_REGS];
  logic [DW-1:0] scr_q [NUM_REGS];
  pcs_state_type state_q;
  logic [AW-1:0] idx_q;
  logic [2:0] div_q;
  logic tick;
  logic start_q;
  logic start_rise;
  logic stall;
  logic [2:0] div_max;

  ////////////////////////////////////////////////////////////////////////
  // wake clock divider
  assign div_max = ctrl_i.wake_clock_divider_select ? `PCS_DIV_FAST - 3'd1
                                                    : `PCS_DIV_SLOW - 3'd1;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 3'h0;
    end else if (div_q >= div_max) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'd1;
    end
  end
  assign tick = (div_q >= div_max);

  ////////////////////////////////////////////////////////////////////////
  // start detection
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= ctrl_i.start_save_bit;
    end
  end
  assign start_rise = ctrl_i.start_save_bit & ~start_q;
  // a port access holds the engine step so no scratch write is dropped
  assign stall = port_req_i;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= PCS_IDLE;
      idx_q <= '0;
    end else begin
      case (state_q)
        PCS_IDLE, PCS_DONE: begin
          idx_q <= '0;
          if (start_rise) begin
            state_q <= PCS_SAVE;
          end else if (off_exit_i) begin
            state_q <= PCS_REST;
          end
        end
        PCS_SAVE: begin
          if (tick && !stall) begin
            if (idx_q == LAST) begin
              state_q <= PCS_DONE;
            end else begin
              idx_q <= idx_q + AW'(1);
            end
          end
        end
        PCS_REST: begin
          if (tick && !stall) begin
            if (idx_q == LAST) begin
              state_q <= PCS_IDLE;
            end else begin
              idx_q <= idx_q + AW'(1);
            end
          end
        end
        default: begin
          state_q <= PCS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage
  always_ff @(posedge mclk_i) begin
    if (state_q == PCS_SAVE && tick && !stall) begin
      scr_q[idx_q] <= pad_q[idx_q];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (state_q == PCS_REST && tick && !stall) begin
      pad_q[idx_q] <= scr_q[idx_q];
    end else if (port_req_i && port_we_i) begin
      pad_q[port_addr_i] <= port_wdata_i;
    end
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_rdata_o <= '0;
      scr_rdata_o <= '0;
    end else begin
      port_rdata_o <= pad_q[port_addr_i];
      scr_rdata_o <= scr_q[scr_addr_i];
    end
  end

  assign save_done_flag_o = (state_q == PCS_DONE);
  assign busy_o = (state_q == PCS_SAVE) || (state_q == PCS_REST);

  ////////////////////////////////////////////////////////////////////////
  // checks
  done_after_start_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    start_rise && state_q != PCS_SAVE && state_q != PCS_REST
    |=> !save_done_flag_o)
    else $error("done high right after start");
  done_needs_last_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(save_done_flag_o) |-> $past(idx_q) == LAST
    && $past(state_q) == PCS_SAVE)
    else $error("done before last write");
  stall_holds_idx_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    busy_o && stall |=> $stable(idx_q))
    else $error("index moved on stall");
  step_on_tick_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_SAVE && tick && !stall && idx_q != LAST
    |=> idx_q == $past(idx_q) + AW'(1))
    else $error("save skipped reg");
  no_tick_hold_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    busy_o && !tick |=> $stable(idx_q))
    else $error("step off tick");
  div_four_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    !ctrl_i.wake_clock_divider_select && div_q == 3'h0 |=> div_q == 3'h1)
    else $error("divider not counting");
  restore_go_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_IDLE && off_exit_i && !start_rise |=> state_q == PCS_REST)
    else $error("restore not started");
  save_go_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_IDLE && start_rise |=> state_q == PCS_SAVE)
    else $error("save not started");
  start_at_zero_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(busy_o) |-> idx_q == '0)
    else $error("walk not from first reg");
  save_end_done_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_SAVE && tick && !stall && idx_q == LAST
    |=> save_done_flag_o)
    else $error("done missing after last write");
  save_stays_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_SAVE && !(tick && !stall && idx_q == LAST)
    |=> state_q == PCS_SAVE)
    else $error("save left before last reg");
  copy_to_scratch_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_SAVE && tick && !stall
    |=> scr_q[$past(idx_q)] == $past(pad_q[idx_q]))
    else $error("scratch copy wrong");
  copy_to_pads_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_REST && tick && !stall
    |=> pad_q[$past(idx_q)] == $past(scr_q[idx_q]))
    else $error("pad restore wrong");
  rest_step_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_REST && tick && !stall && idx_q != LAST
    |=> idx_q == $past(idx_q) + AW'(1))
    else $error("restore skipped reg");
  rest_end_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_q == PCS_REST && tick && !stall && idx_q == LAST
    |=> state_q == PCS_IDLE)
    else $error("restore did not end");
  done_holds_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    save_done_flag_o && !start_rise && !off_exit_i |=> save_done_flag_o)
    else $error("done dropped early");
  tick_four_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    !ctrl_i.wake_clock_divider_select && tick
    ##1 !ctrl_i.wake_clock_divider_select [*4] |-> tick)
    else $error("divide by four period wrong");
  tick_two_a: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    ctrl_i.wake_clock_divider_select && tick
    ##1 ctrl_i.wake_clock_divider_select [*2] |-> tick)
    else $error("divide by two period wrong");
endmodule // pcs_context_save
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the context save engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcs_pkg::*;
  localparam int NR = 4;
  logic mclk_i, arst_n_i, off_exit_i, done, busy, req, we;
  pcs_ctrl_type ctrl_i;
  logic [1:0] addr, saddr;
  logic [31:0] wd, rdat, sdat;
  logic [31:0] rows [NR] = '{32'h0000_00a5, 32'hdead_beef,
                             32'h1234_5678, 32'hffff_0001};
  // one save per row: select, stall cycles and data mask in, done window out
  typedef struct {
    logic dv;
    int hold;
    logic [31:0] mask;
    int lo;
    int hi;
  } pcs_case_type;
  localparam int NC = 3;
  pcs_case_type cases [NC] = '{
    '{1'b0, 0, 32'h0000_0000, (NR - 1) * 4 + 1, NR * 4 + 2},
    '{1'b1, 0, 32'hffff_ffff, (NR - 1) * 2 + 1, NR * 2 + 2},
    '{1'b0, 20, 32'h5a5a_5a5a, 21, 21 + NR * 4 + 2}};
  // software wait before polling: twice the divide-by-4 save time plus 10%
  localparam int TS_WAIT = (2 * 4 * NR * 11 + 9) / 10;
  int bad_count = 0;
  int n_tests = 0;
  int n;
  pcs_context_save #(.NUM_REGS(NR)) DUT (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .ctrl_i(ctrl_i), .off_exit_i(off_exit_i),
    .save_done_flag_o(done), .busy_o(busy), .port_req_i(req),
    .port_addr_i(addr), .port_we_i(we), .port_wdata_i(wd),
    .port_rdata_o(rdat), .scr_addr_i(saddr), .scr_rdata_o(sdat));
  initial begin
    mclk_i = 0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    @(negedge mclk_i);
    req = 1;
    we = 1;
    addr = a[1:0];
    wd = d;
    @(negedge mclk_i);
    req = 0;
    we = 0;
  endtask
  task automatic rd(input int a);
    @(negedge mclk_i);
    req = 1;
    addr = a[1:0];
    saddr = a[1:0];
    @(negedge mclk_i);
    req = 0;
  endtask
  // start a save, optionally stalling it with port traffic
  task automatic save(input logic dv, input int hold, lo, hi);
    @(negedge mclk_i);
    ctrl_i.wake_clock_divider_select = dv;
    @(negedge mclk_i);
    ctrl_i.start_save_bit = 1;
    req = (hold > 0);
    @(negedge mclk_i);
    chk({30'h0, done, busy}, 32'h1);
    ctrl_i.start_save_bit = 0;
    n = 1;
    repeat (hold) begin
      @(negedge mclk_i);
      n++;
      chk({31'h0, done}, 32'h0);
    end
    req = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  initial begin
    #100us;
    bad_count++;
    end_of_test();
  end
  initial begin
    ctrl_i = '0;
    off_exit_i = 0;
    {req, we, addr, saddr, wd} = '0;
    arst_n_i = 0;
    repeat (16) @(negedge mclk_i);
    chk({30'h0, done, busy}, 32'h0);
    arst_n_i = 1;
    // table of ordinary saves
    for (int c = 0; c < NC; c++) begin
      for (int i = 0; i < NR; i++) wr(i, rows[i] ^ cases[c].mask);
      save(cases[c].dv, cases[c].hold, cases[c].lo, cases[c].hi);
      for (int i = 0; i < NR; i++) begin
        rd(i);
        chk(sdat, rows[i] ^ cases[c].mask);
        chk(rdat, rows[i] ^ cases[c].mask);
      end
    end
    // off-mode exit: pads get the last saved copy back
    for (int i = 0; i < NR; i++) wr(i, ~(rows[i] ^ cases[NC - 1].mask));
    @(negedge mclk_i);
    off_exit_i = 1;
    @(negedge mclk_i);
    off_exit_i = 0;
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
    for (int i = 0; i < NR; i++) begin
      rd(i);
      chk(rdat, rows[i] ^ cases[NC - 1].mask);
    end
    // software flow: start, wait the save time plus margin, poll once
    for (int i = 0; i < NR; i++) wr(i, rows[i]);
    @(negedge mclk_i);
    ctrl_i.start_save_bit = 1;
    @(negedge mclk_i);
    ctrl_i.start_save_bit = 0;
    repeat (TS_WAIT) @(negedge mclk_i);
    chk({31'h0, done}, 32'h1);
    for (int i = 0; i < NR; i++) begin
      rd(i);
      chk(sdat, rows[i]);
      chk(rdat, rows[i]);
    end
    // reset in the middle of a save, then a clean save
    for (int i = 0; i < NR; i++) wr(i, ~rows[i]);
    @(negedge mclk_i);
    ctrl_i.start_save_bit = 1;
    @(negedge mclk_i);
    ctrl_i.start_save_bit = 0;
    repeat (3) @(negedge mclk_i);
    arst_n_i = 0;
    @(negedge mclk_i);
    chk({30'h0, done, busy}, 32'h0);
    arst_n_i = 1;
    save(1'b0, 0, (NR - 1) * 4 + 1, NR * 4 + 2);
    for (int i = 0; i < NR; i++) begin
      rd(i);
      chk(sdat, ~rows[i]);
    end
    end_of_test();
  end
endmodule // tb
`default_nettype wire
